// *** verilog/phia_device.sv ***
// Device end of the parallel host port with bus style detection.
// Summary of operation
// - Separate-strobe muxed: latch address while ALE high.
// - Common-strobe muxed: latch address while ALE high.
// - Handshake: latch address while address strobe low.
// - Handshake: wait low starts, high ends access.
// - Dedicated modes: three address pins form address.
// - Eight shared bidirectional data lines carry address/data.
// - Power-down pin high: everything off, pads disconnected.
// - Power-down falling edge starts internal reset phase.
// - Separate dedicated: read, write, select, three address.
// - Muxed: address on low six, data eight.
// - Common strobe: direction line, data strobe, select.
// - Handshake only muxed, with its four controls.
// - After reset clear mode, then detect style.
// - Style comes from control pin levels, routine.
// - Host straps pins according to bus style.
// - Wait stays off until first address strobe.
// - Host never reads address in handshake mode.
// - Handshake: select gates strobe or tied low.
`timescale 1ns/1ps
`default_nettype none
`include "phia_defs.svh"
module phia_device (
  input wire logic clk_sys,
  input wire logic rst,
  phia_if.dev bus,
  output logic pd_active,
  output phia_pkg::phia_mode_t mode,
  output logic wr_stb,
  output logic [5:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_stb,
  output logic [5:0] rd_addr,
  input wire logic [7:0] rd_data
);
  // ----------------------------------------------------------------
  // Pin synchronisers and pad gating.
  // ----------------------------------------------------------------
  logic [7:0] ctl_s1_reg;
  logic [7:0] ctl_s2_reg;
  logic [7:0] dat_s1_reg;
  logic [7:0] dat_s2_reg;
  logic reset_powerdown_in_s;
  logic [7:0] ctl;
  logic [7:0] din;
  logic ale;
  logic a0;
  logic a1;
  logic a2;
  logic rd_n;
  logic wr_n;
  logic cs_n;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctl_s1_reg <= `PHIA_CTL_IDLE;
      ctl_s2_reg <= `PHIA_CTL_IDLE;
      dat_s1_reg <= `PHIA_DATA_IDLE;
      dat_s2_reg <= `PHIA_DATA_IDLE;
    end else begin
      ctl_s1_reg <= {bus.ale, bus.a0, bus.a1, bus.a2, bus.rd_n, bus.wr_n, bus.cs_n, bus.reset_powerdown_in};
      ctl_s2_reg <= ctl_s1_reg;
      dat_s1_reg <= bus.d;
      dat_s2_reg <= dat_s1_reg;
    end
  end
  assign reset_powerdown_in_s = ctl_s2_reg[`PHIA_P_RESET_POWERDOWN_IN];
  assign ctl = reset_powerdown_in_s ? `PHIA_CTL_IDLE : ctl_s2_reg;
  assign din = reset_powerdown_in_s ? `PHIA_DATA_IDLE : dat_s2_reg;
  assign ale = ctl[`PHIA_P_ALE];
  assign a0 = ctl[`PHIA_P_A0];
  assign a1 = ctl[`PHIA_P_A1];
  assign a2 = ctl[`PHIA_P_A2];
  assign rd_n = ctl[`PHIA_P_RD];
  assign wr_n = ctl[`PHIA_P_WR];
  assign cs_n = ctl[`PHIA_P_CS];
  assign pd_active = reset_powerdown_in_s;

  // ----------------------------------------------------------------
  // Reset phase and bus style detection.
  // ----------------------------------------------------------------
  phia_pkg::phia_dev_state_t state_reg;
  phia_pkg::phia_dev_state_t state_next;
  phia_pkg::phia_mode_t mode_reg;
  phia_pkg::phia_mode_t mode_next;
  logic [`PHIA_CNT_W-1:0] cnt_reg;
  logic [`PHIA_CNT_W-1:0] cnt_next;
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    cnt_next = cnt_reg;
    if (reset_powerdown_in_s) begin
      state_next = phia_pkg::PHIA_DEV_PD;
      mode_next = phia_pkg::PHIA_NONE;
      cnt_next = '0;
    end else begin
      unique case (state_reg)
        phia_pkg::PHIA_DEV_PD: begin
          state_next = phia_pkg::PHIA_DEV_RSTPH;
          cnt_next = '0;
        end
        phia_pkg::PHIA_DEV_RSTPH: begin
          if (cnt_reg == `PHIA_CNT_W'(`PHIA_RST_PHASE_CYC - 1)) begin
            state_next = phia_pkg::PHIA_DEV_DETECT;
          end else begin
            cnt_next = cnt_reg + `PHIA_CNT_W'(1);
          end
        end
        phia_pkg::PHIA_DEV_DETECT: begin
          if (a2 && a1) begin
            mode_next = phia_pkg::PHIA_HS_MUX;
            state_next = phia_pkg::PHIA_DEV_RUN;
          end else if (!a2 && a1 && a0) begin
            mode_next = phia_pkg::PHIA_SEP_MUX;
            state_next = phia_pkg::PHIA_DEV_RUN;
          end else if (!a2 && a1 && !a0) begin
            mode_next = phia_pkg::PHIA_COM_MUX;
            state_next = phia_pkg::PHIA_DEV_RUN;
          end else if (ale) begin
            state_next = phia_pkg::PHIA_DEV_DEDWAIT;
          end
        end
        phia_pkg::PHIA_DEV_DEDWAIT: begin
          if (!cs_n && !rd_n && !wr_n) begin
            mode_next = phia_pkg::PHIA_COM_DED;
            state_next = phia_pkg::PHIA_DEV_RUN;
          end else if (!cs_n && (!rd_n || !wr_n)) begin
            mode_next = phia_pkg::PHIA_SEP_DED;
            state_next = phia_pkg::PHIA_DEV_RUN;
          end
        end
        phia_pkg::PHIA_DEV_RUN: state_next = phia_pkg::PHIA_DEV_RUN;
        default: state_next = phia_pkg::PHIA_DEV_PD;
      endcase
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= phia_pkg::PHIA_DEV_PD;
      mode_reg <= phia_pkg::PHIA_NONE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      cnt_reg <= cnt_next;
    end
  end
  assign mode = mode_reg;
  // ----------------------------------------------------------------
  // Access decode, address latch and data path.
  // ----------------------------------------------------------------
  logic rd_act;
  logic wr_act;
  logic [5:0] addr_reg;
  logic [5:0] addr_next;
  logic prev_rd_reg;
  logic prev_wr_reg;
  logic rd_stb_reg;
  logic rd_stb_next;
  logic wr_stb_reg;
  logic wr_stb_next;
  logic [7:0] wdat_reg;
  logic [7:0] wdat_next;
  logic [7:0] dout_reg;
  logic [7:0] dout_next;
  always_comb begin
    rd_act = 1'h0;
    wr_act = 1'h0;
    addr_next = addr_reg;
    unique case (mode_reg)
      phia_pkg::PHIA_SEP_DED, phia_pkg::PHIA_SEP_MUX: begin
        rd_act = !cs_n && !rd_n;
        wr_act = !cs_n && !wr_n;
      end
      phia_pkg::PHIA_COM_DED, phia_pkg::PHIA_COM_MUX, phia_pkg::PHIA_HS_MUX: begin
        rd_act = !cs_n && !rd_n && wr_n;
        wr_act = !cs_n && !rd_n && !wr_n;
      end
      default: rd_act = 1'h0;
    endcase
    if (phia_pkg::phia_is_ded(mode_reg)) begin
      addr_next = {`PHIA_DED_PAD, a2, a1, a0};
    end else if ((mode_reg == phia_pkg::PHIA_SEP_MUX) && ale) begin
      addr_next = din[`PHIA_AW-1:0];
    end else if ((mode_reg == phia_pkg::PHIA_COM_MUX) && ale) begin
      addr_next = din[`PHIA_AW-1:0];
    end else if ((mode_reg == phia_pkg::PHIA_HS_MUX) && !ale) begin
      addr_next = din[`PHIA_AW-1:0];
    end
    rd_stb_next = rd_act && !prev_rd_reg;
    wr_stb_next = prev_wr_reg && !wr_act;
    wdat_next = wr_act ? din : wdat_reg;
    dout_next = rd_act ? rd_data : dout_reg;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_reg <= '0;
      prev_rd_reg <= 1'h0;
      prev_wr_reg <= 1'h0;
      rd_stb_reg <= 1'h0;
      wr_stb_reg <= 1'h0;
      wdat_reg <= '0;
      dout_reg <= '0;
    end else begin
      addr_reg <= addr_next;
      prev_rd_reg <= rd_act;
      prev_wr_reg <= wr_act;
      rd_stb_reg <= rd_stb_next;
      wr_stb_reg <= wr_stb_next;
      wdat_reg <= wdat_next;
      dout_reg <= dout_next;
    end
  end

  assign wr_stb = wr_stb_reg;
  assign wr_addr = addr_reg;
  assign wr_data = wdat_reg;
  assign rd_stb = rd_stb_reg;
  assign rd_addr = addr_reg;
  assign bus.d_d = dout_reg;
  assign bus.d_d_oe = rd_act;

  // ----------------------------------------------------------------
  // Handshake wait output.
  // ----------------------------------------------------------------
  logic hs;
  logic acc;
  logic prev_ale_reg;
  logic wait_oe_reg;
  logic wait_oe_next;
  logic done_reg;
  logic done_next;
  logic [`PHIA_CNT_W-1:0] wcnt_reg;
  logic [`PHIA_CNT_W-1:0] wcnt_next;
  always_comb begin
    hs = (mode_reg == phia_pkg::PHIA_HS_MUX);
    acc = hs && (!ale || rd_act || wr_act);
    wait_oe_next = hs && (wait_oe_reg || (!ale && prev_ale_reg));
    done_next = done_reg;
    wcnt_next = wcnt_reg;
    if (!acc || ((rd_act || wr_act) != (prev_rd_reg || prev_wr_reg))) begin
      done_next = 1'h0;
      wcnt_next = '0;
    end else if (!done_reg) begin
      if (wcnt_reg == `PHIA_CNT_W'(`PHIA_WAIT_CYC - 1)) begin
        done_next = 1'h1;
      end else begin
        wcnt_next = wcnt_reg + `PHIA_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_ale_reg <= 1'h1;
      wait_oe_reg <= 1'h0;
      done_reg <= 1'h0;
      wcnt_reg <= '0;
    end else begin
      prev_ale_reg <= ale;
      wait_oe_reg <= wait_oe_next;
      done_reg <= done_next;
      wcnt_reg <= wcnt_next;
    end
  end
  assign bus.a0_d = done_reg;
  assign bus.a0_d_oe = wait_oe_reg;
endmodule
`default_nettype wire

// *** verilog/phia_defs.svh ***
// Timing counts, pin positions and idle values of the parallel host port.
`ifndef PHIA_DEFS_SVH
`define PHIA_DEFS_SVH
`define PHIA_CLK_MHZ 50
`define PHIA_RST_PHASE_NS 1000
`define PHIA_RST_PHASE_CYC ((`PHIA_RST_PHASE_NS * `PHIA_CLK_MHZ + 999) / 1000)
`define PHIA_WAIT_NS 100
`define PHIA_WAIT_CYC ((`PHIA_WAIT_NS * `PHIA_CLK_MHZ + 999) / 1000)
`define PHIA_STB_NS 200
`define PHIA_STB_CYC ((`PHIA_STB_NS * `PHIA_CLK_MHZ + 999) / 1000)
`define PHIA_CNT_W 8
`define PHIA_AW 6
`define PHIA_DW 8
`define PHIA_P_ALE 7
`define PHIA_P_A0 6
`define PHIA_P_A1 5
`define PHIA_P_A2 4
`define PHIA_P_RD 3
`define PHIA_P_WR 2
`define PHIA_P_CS 1
`define PHIA_P_RESET_POWERDOWN_IN 0
`define PHIA_CTL_IDLE 8'hFF
`define PHIA_DATA_IDLE 8'hFF
`define PHIA_DED_PAD 3'h0
`endif

// *** verilog/phia_pkg.sv ***
// Types shared by both ends of the parallel host port.
`default_nettype none
package phia_pkg;
  typedef enum logic [2:0] {
    PHIA_NONE = 3'b000,
    PHIA_SEP_DED = 3'b001,
    PHIA_SEP_MUX = 3'b010,
    PHIA_COM_DED = 3'b011,
    PHIA_COM_MUX = 3'b100,
    PHIA_HS_MUX = 3'b101
  } phia_mode_t;

  typedef enum logic [2:0] {
    PHIA_DEV_PD = 3'b000,
    PHIA_DEV_RSTPH = 3'b001,
    PHIA_DEV_DETECT = 3'b010,
    PHIA_DEV_DEDWAIT = 3'b011,
    PHIA_DEV_RUN = 3'b100
  } phia_dev_state_t;

  typedef enum logic [1:0] {
    PHIA_HST_IDLE = 2'b00,
    PHIA_HST_ADDR = 2'b01,
    PHIA_HST_DATA = 2'b10,
    PHIA_HST_REC = 2'b11
  } phia_hst_state_t;

  function automatic logic phia_is_ded(input phia_mode_t m);
    phia_is_ded = (m == PHIA_SEP_DED) || (m == PHIA_COM_DED);
  endfunction
endpackage
`default_nettype wire

// *** verilog/phia_if.sv ***
// Pin bundle joining the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
`include "phia_defs.svh"
interface phia_if;
  logic ale;
  logic a1;
  logic a2;
  logic rd_n;
  logic wr_n;
  logic cs_n;
  logic reset_powerdown_in;
  logic a0_h;
  logic a0_h_oe;
  logic a0_d;
  logic a0_d_oe;
  logic [7:0] d_h;
  logic d_h_oe;
  logic [7:0] d_d;
  logic d_d_oe;
  logic a0;
  logic [7:0] d;

  // Wire levels; an undriven line floats high.
  assign a0 = a0_d_oe ? a0_d : (a0_h_oe ? a0_h : 1'h1);
  assign d = d_d_oe ? d_d : (d_h_oe ? d_h : `PHIA_DATA_IDLE);

  modport dev(input ale, a0, a1, a2, rd_n, wr_n, cs_n, reset_powerdown_in, d,
              output a0_d, a0_d_oe, d_d, d_d_oe);
  modport host(output ale, a1, a2, rd_n, wr_n, cs_n, reset_powerdown_in, a0_h, a0_h_oe, d_h, d_h_oe,
               input a0, d);
endinterface
`default_nettype wire

// *** verilog/phia_host.sv ***
// Host end of the parallel host port: straps pins and runs bus cycles.
`timescale 1ns/1ps
`default_nettype none
`include "phia_defs.svh"
module phia_host (
  input wire logic clk_sys,
  input wire logic rst,
  phia_if.host bus,
  input wire phia_pkg::phia_mode_t mode_sel,
  input wire logic pd_req,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [5:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata
);
  // ----------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------
  logic [8:0] in_s1_reg;
  logic [8:0] in_s2_reg;
  logic wait_s;
  logic [7:0] din_s;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_s1_reg <= 9'h1FF;
      in_s2_reg <= 9'h1FF;
    end else begin
      in_s1_reg <= {bus.a0, bus.d};
      in_s2_reg <= in_s1_reg;
    end
  end

  assign wait_s = in_s2_reg[8];
  assign din_s = in_s2_reg[7:0];

  // ----------------------------------------------------------------
  // Strobe encoding per style, as {cs_n, rd_n, wr_n}.
  // ----------------------------------------------------------------
  function automatic logic [2:0] phia_strobes(input phia_pkg::phia_mode_t m, input logic wr);
    if ((m == phia_pkg::PHIA_SEP_DED) || (m == phia_pkg::PHIA_SEP_MUX)) begin
      phia_strobes = wr ? 3'h2 : 3'h1;
    end else begin
      phia_strobes = wr ? 3'h0 : 3'h1;
    end
  endfunction

  function automatic logic [2:0] phia_idle_ctl(input phia_pkg::phia_mode_t m);
    phia_idle_ctl = (m == phia_pkg::PHIA_HS_MUX) ? 3'h3 : 3'h7;
  endfunction

  function automatic logic phia_idle_ale(input phia_pkg::phia_mode_t m);
    phia_idle_ale = !((m == phia_pkg::PHIA_SEP_MUX) || (m == phia_pkg::PHIA_COM_MUX));
  endfunction

  // ----------------------------------------------------------------
  // Bus cycle sequencer.
  // ----------------------------------------------------------------
  phia_pkg::phia_hst_state_t st_reg;
  phia_pkg::phia_hst_state_t st_next;
  logic [`PHIA_CNT_W-1:0] cnt_reg;
  logic [`PHIA_CNT_W-1:0] cnt_next;
  logic ale_reg;
  logic ale_next;
  logic [2:0] a_reg;
  logic [2:0] a_next;
  logic [2:0] ctl_reg;
  logic [2:0] ctl_next;
  logic [7:0] d_reg;
  logic [7:0] d_next;
  logic d_oe_reg;
  logic d_oe_next;
  logic wr_cmd_reg;
  logic wr_cmd_next;
  logic [7:0] wdat_reg;
  logic [7:0] wdat_next;
  logic rsp_valid_reg;
  logic rsp_valid_next;
  logic [7:0] rsp_reg;
  logic [7:0] rsp_next;
  logic reset_powerdown_in_reg;
  logic hs;
  logic ded;
  logic phase_end;

  always_comb begin
    hs = (mode_sel == phia_pkg::PHIA_HS_MUX);
    ded = phia_pkg::phia_is_ded(mode_sel);
    phase_end = (cnt_reg >= `PHIA_CNT_W'(`PHIA_STB_CYC - 1)) && (!hs || wait_s);
    st_next = st_reg;
    cnt_next = (cnt_reg < `PHIA_CNT_W'(`PHIA_STB_CYC - 1)) ? cnt_reg + `PHIA_CNT_W'(1) : cnt_reg;
    ale_next = ale_reg;
    a_next = a_reg;
    ctl_next = ctl_reg;
    d_next = d_reg;
    d_oe_next = d_oe_reg;
    wr_cmd_next = wr_cmd_reg;
    wdat_next = wdat_reg;
    rsp_valid_next = 1'h0;
    rsp_next = rsp_reg;
    if (!ded) begin
      unique case (mode_sel)
        phia_pkg::PHIA_SEP_MUX: a_next = 3'h3;
        phia_pkg::PHIA_COM_MUX: a_next = 3'h2;
        default: a_next = 3'h6;
      endcase
    end
    unique case (st_reg)
      phia_pkg::PHIA_HST_IDLE: begin
        a_next = ded ? 3'h0 : a_next;
        ale_next = phia_idle_ale(mode_sel);
        ctl_next = phia_idle_ctl(mode_sel);
        d_oe_next = 1'h0;
        if (cmd_valid) begin
          wr_cmd_next = cmd_write;
          wdat_next = cmd_wdata;
          cnt_next = '0;
          st_next = phia_pkg::PHIA_HST_ADDR;
          if (ded) begin
            a_next = cmd_addr[2:0];
          end else begin
            d_next = {2'h0, cmd_addr};
            d_oe_next = 1'h1;
            ale_next = !hs;
            ctl_next = hs ? 3'h2 : ctl_next;
          end
        end
      end
      phia_pkg::PHIA_HST_ADDR: begin
        if (phase_end) begin
          ale_next = phia_idle_ale(mode_sel);
          ctl_next = phia_strobes(mode_sel, wr_cmd_reg);
          d_next = wdat_reg;
          d_oe_next = wr_cmd_reg;
          cnt_next = '0;
          st_next = phia_pkg::PHIA_HST_DATA;
        end
      end
      phia_pkg::PHIA_HST_DATA: begin
        if (phase_end) begin
          rsp_next = wr_cmd_reg ? rsp_reg : din_s;
          ctl_next = phia_idle_ctl(mode_sel);
          d_oe_next = 1'h0;
          cnt_next = '0;
          st_next = phia_pkg::PHIA_HST_REC;
        end
      end
      phia_pkg::PHIA_HST_REC: begin
        if (cnt_reg == `PHIA_CNT_W'(`PHIA_STB_CYC - 1)) begin
          rsp_valid_next = 1'h1;
          st_next = phia_pkg::PHIA_HST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= phia_pkg::PHIA_HST_IDLE;
      cnt_reg <= '0;
      ale_reg <= 1'h1;
      a_reg <= 3'h0;
      ctl_reg <= 3'h7;
      d_reg <= '0;
      d_oe_reg <= 1'h0;
      wr_cmd_reg <= 1'h0;
      wdat_reg <= '0;
      rsp_valid_reg <= 1'h0;
      rsp_reg <= '0;
      reset_powerdown_in_reg <= 1'h1;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      ale_reg <= ale_next;
      a_reg <= a_next;
      ctl_reg <= ctl_next;
      d_reg <= d_next;
      d_oe_reg <= d_oe_next;
      wr_cmd_reg <= wr_cmd_next;
      wdat_reg <= wdat_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_reg <= rsp_next;
      reset_powerdown_in_reg <= pd_req;
    end
  end

  assign cmd_ready = (st_reg == phia_pkg::PHIA_HST_IDLE);
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rsp_reg;
  assign bus.ale = ale_reg;
  assign bus.a2 = a_reg[2];
  assign bus.a1 = a_reg[1];
  assign bus.a0_h = a_reg[0];
  assign bus.a0_h_oe = !hs;
  assign bus.cs_n = ctl_reg[2];
  assign bus.rd_n = ctl_reg[1];
  assign bus.wr_n = ctl_reg[0];
  assign bus.d_h = d_reg;
  assign bus.d_h_oe = d_oe_reg;
  assign bus.reset_powerdown_in = reset_powerdown_in_reg;
endmodule
`default_nettype wire

// *** bench/phia_assertions.sv ***
// Concurrent checks on the pins between the host end and the device end.
`timescale 1ns/1ps
`default_nettype none
module phia_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ale,
  input wire logic a1,
  input wire logic a2,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic reset_powerdown_in,
  input wire logic a0_h_oe,
  input wire logic a0_d_oe,
  input wire logic d_h_oe,
  input wire logic d_d_oe,
  input wire logic a0
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // History of the address strobe
  // ----------------------------------------
  logic [3:0] ale_low_hist_reg;
  logic [3:0] ale_low_hist_next;

  always_comb begin
    ale_low_hist_next = {ale_low_hist_reg[2:0], !ale};
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ale_low_hist_reg <= 4'h0;
    end else begin
      ale_low_hist_reg <= ale_low_hist_next;
    end
  end

  // ----------------------------------------
  // Handshake steps
  // ----------------------------------------
  sequence hs_start_s;
    a0_d_oe && a2 && a1 && $fell(rd_n);
  endsequence

  sequence hs_end_s;
    a0_d_oe && a2 && a1 && $rose(rd_n);
  endsequence

  sequence wait_cycle_s;
    ##3 !a0 [*5] ##1 a0;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  data_drive_a: assert property (d_d_oe |-> $past(!rd_n && wr_n, 2))
    else $error("Device drives data outside a read.");
  bus_clash_a: assert property (!(d_d_oe && d_h_oe))
    else $error("Both ends drive the data lines.");
  wait_pin_a: assert property (a0_d_oe |-> a2 && a1 && !a0_h_oe)
    else $error("Wait output driven outside handshake style.");
  wait_cycle_a: assert property (hs_start_s |-> wait_cycle_s)
    else $error("Wait output did not end the access in time.");
  wait_release_a: assert property (hs_end_s |-> ##[1:5] !a0)
    else $error("Wait output did not return low after the strobe.");
  wait_enable_a: assert property ($rose(a0_d_oe) |-> ale_low_hist_reg != 4'h0)
    else $error("Wait output enabled without an address strobe.");
  pd_release_a: assert property (reset_powerdown_in [*5] |-> !d_d_oe && !a0_d_oe)
    else $error("Device drives pins while powered down.");
  no_addr_read_a: assert property ($fell(ale) && a2 && a1 |-> !wr_n)
    else $error("Host issued an address read in handshake style.");
endmodule
`default_nettype wire

// *** bench/phia_tb.sv ***
// Self-checking bench joining the host end and the device end of the port.
`timescale 1ns/1ps
`default_nettype none
module phia_tb;
  typedef struct {
    phia_pkg::phia_mode_t m;
    logic [5:0] a;
    logic [7:0] dt;
    logic [5:0] ea;
  } phia_row_t;

  localparam int LIMIT = 20000;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  phia_pkg::phia_mode_t mode_sel = phia_pkg::PHIA_SEP_DED;
  logic pd_req = 1'h1;
  logic cmd_valid = 1'h0;
  logic cmd_write = 1'h0;
  logic [5:0] cmd_addr = 6'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready, rsp_valid, pd_active, wr_stb, rd_stb;
  logic [7:0] rsp_rdata, wr_data, rd_data, got_data;
  logic [5:0] wr_addr, rd_addr, got_addr, got_raddr;
  phia_pkg::phia_mode_t mode;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  phia_row_t rows [6];

  // ----------------------------------------
  // Design and checker
  // ----------------------------------------
  phia_if phia_if_i ();
  phia_device phia_device_i (.clk_sys(clk_sys), .rst(rst), .bus(phia_if_i),
    .pd_active(pd_active), .mode(mode), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data));
  phia_host phia_host_i (.clk_sys(clk_sys), .rst(rst), .bus(phia_if_i),
    .mode_sel(mode_sel), .pd_req(pd_req), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  phia_assertions phia_assertions_i (.clk_sys(clk_sys), .rst(rst),
    .ale(phia_if_i.ale), .a1(phia_if_i.a1), .a2(phia_if_i.a2), .rd_n(phia_if_i.rd_n),
    .wr_n(phia_if_i.wr_n), .reset_powerdown_in(phia_if_i.reset_powerdown_in), .a0_h_oe(phia_if_i.a0_h_oe),
    .a0_d_oe(phia_if_i.a0_d_oe), .d_h_oe(phia_if_i.d_h_oe), .d_d_oe(phia_if_i.d_d_oe),
    .a0(phia_if_i.a0));

  // ----------------------------------------
  // Clock, read data pattern and monitors
  // ----------------------------------------
  assign rd_data = 8'h5A ^ {2'h0, rd_addr};
  always #10 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (wr_stb === 1'h1) begin
      got_addr <= wr_addr;
      got_data <= wr_data;
    end
    if (rd_stb === 1'h1) begin
      got_raddr <= rd_addr;
    end
  end

  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      bad_count = bad_count + 1;
      close_out();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_cmd(input logic w, input logic [5:0] a, input logic [7:0] dt);
    int n;
    n = 0;
    while (cmd_ready !== 1'h1 && n < 100) begin
      @(posedge clk_sys);
      #1;
      n = n + 1;
    end
    cmd_valid = 1'h1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = dt;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'h0;
    n = 0;
    while (rsp_valid !== 1'h1 && n < 200) begin
      @(posedge clk_sys);
      #1;
      n = n + 1;
    end
    check({7'h00, rsp_valid}, 8'h01);
  endtask

  task automatic power_up(input phia_pkg::phia_mode_t m);
    pd_req = 1'h1;
    mode_sel = m;
    repeat (10) @(posedge clk_sys);
    #1;
    check({7'h00, pd_active}, 8'h01);
    check({5'h00, mode}, {5'h00, phia_pkg::PHIA_NONE});
    pd_req = 1'h0;
    repeat (30) @(posedge clk_sys);
    #1;
    check({7'h00, pd_active}, 8'h00);
    check({5'h00, mode}, {5'h00, phia_pkg::PHIA_NONE});
    repeat (60) @(posedge clk_sys);
    #1;
  endtask

  task automatic close_out();
    $display("counts: checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows = '{'{phia_pkg::PHIA_SEP_DED, 6'h05, 8'hA5, 6'h05},
             '{phia_pkg::PHIA_SEP_DED, 6'h3A, 8'h01, 6'h02},
             '{phia_pkg::PHIA_COM_DED, 6'h07, 8'h00, 6'h07},
             '{phia_pkg::PHIA_SEP_MUX, 6'h3F, 8'hFF, 6'h3F},
             '{phia_pkg::PHIA_COM_MUX, 6'h00, 8'h5A, 6'h00},
             '{phia_pkg::PHIA_HS_MUX, 6'h2C, 8'hC3, 6'h2C}};
    repeat (8) @(posedge clk_sys);
    #1;
    rst = 1'h0;
    repeat (4) @(posedge clk_sys);
    #1;
    check({5'h00, mode}, {5'h00, phia_pkg::PHIA_NONE});
    check({7'h00, pd_active}, 8'h01);
    check({7'h00, phia_if_i.d_d_oe}, 8'h00);
    $display("test reset finished");
    for (int i = 0; i < 6; i++) begin
      power_up(rows[i].m);
      do_cmd(1'h1, rows[i].a, rows[i].dt);
      check({2'h0, got_addr}, {2'h0, rows[i].ea});
      check(got_data, rows[i].dt);
      check({5'h00, mode}, {5'h00, rows[i].m});
      do_cmd(1'h0, rows[i].a, 8'h00);
      check(rsp_rdata, 8'h5A ^ {2'h0, rows[i].ea});
      check({2'h0, got_raddr}, {2'h0, rows[i].ea});
      $display("test row %0d finished", i);
    end
    do_cmd(1'h1, 6'h3F, 8'hFF);
    do_cmd(1'h1, 6'h00, 8'h00);
    check({2'h0, got_addr}, 8'h00);
    check(got_data, 8'h00);
    do_cmd(1'h0, 6'h3F, 8'h00);
    check(rsp_rdata, 8'h65);
    check({2'h0, got_raddr}, 8'h3F);
    $display("test back to back finished");
    pd_req = 1'h1;
    repeat (5) @(posedge clk_sys);
    #1;
    check({7'h00, phia_if_i.a0_d_oe}, 8'h00);
    check({5'h00, mode}, {5'h00, phia_pkg::PHIA_NONE});
    $display("test power down finished");
    rst = 1'h1;
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'h0;
    @(posedge clk_sys);
    #1;
    check({5'h00, mode}, {5'h00, phia_pkg::PHIA_NONE});
    $display("test second reset finished");
    close_out();
  end
endmodule
`default_nettype wire
